// file: verilog/e1pm_pkg.sv
// e1pm_pkg: shared constants for the e1 error performance counters
// assumes a 25 mhz sys_clk that is also the receive bit-rate reference
package e1pm_pkg;

  // register map, byte addresses on the 8-bit control port
  localparam logic [7:0] ADDR_VIOL_HIGH = 8'h00;
  localparam logic [7:0] ADDR_VIOL_LOW = 8'h01;
  localparam logic [7:0] ADDR_FAS_HIGH_CRC_TOP = 8'h02;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h03;
  localparam logic [7:0] ADDR_FAS_LOW_EBIT_TOP = 8'h04;
  localparam logic [7:0] ADDR_EBIT_LOW = 8'h05;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h11;
  localparam logic [7:0] ADDR_INT_MASK = 8'h12;

  // control register fields
  localparam int CTRL_INTERVAL_BIT = 0;
  localparam int CTRL_VIOL_MODE_BIT = 1;
  localparam int CTRL_HDB3_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // interrupt status and mask fields
  localparam int INT_TIMER_BIT = 0;
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam logic [7:0] INT_MASK_RESET = 8'h00;

  // counter widths
  localparam int VIOL_W = 16;
  localparam int CRC_W = 10;
  localparam int EBIT_W = 10;
  localparam int FAS_W = 12;

  // interval timing
  localparam int CLK_MHZ = 25;
  localparam int INTERVAL_LONG_US = 1000000;
  localparam int INTERVAL_SHORT_US = 62500;
  localparam int INTERVAL_LONG_CYCLES = INTERVAL_LONG_US * CLK_MHZ;
  localparam int INTERVAL_SHORT_CYCLES = INTERVAL_SHORT_US * CLK_MHZ;

endpackage

// file: verilog/e1pm_viol_if.sv
// e1pm_viol_if: carries line symbols and mode bits to the violation detector
// assumes one sys_clk domain; all signals change after a rising edge
`timescale 1ns/1ps
interface e1pm_viol_if;
  logic bit_valid;
  logic pos_mark;
  logic neg_mark;
  logic violation_mode_select;
  logic hdb3_receive_enable;
  logic viol_event;

  modport detector
  (
    input bit_valid,
    input pos_mark,
    input neg_mark,
    input violation_mode_select,
    input hdb3_receive_enable,
    output viol_event
  );

  modport counter
  (
    output bit_valid,
    output pos_mark,
    output neg_mark,
    output violation_mode_select,
    output hdb3_receive_enable,
    input viol_event
  );
endinterface

// file: verilog/e1pm_viol_detect.sv
// e1pm_viol_detect: finds bipolar or code violations in the received symbols
// assumes one bit_valid pulse per received bit time, pos/neg not both high
`timescale 1ns/1ps
module e1pm_viol_detect
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // symbols, mode and result
  e1pm_viol_if.detector vif
);

  typedef struct packed {
    logic have_mark;
    logic last_mark_neg;
    logic have_viol;
    logic last_viol_neg;
    logic [1:0] zero_run;
    logic viol_event;
  } e1pm_det_state_t;

  e1pm_det_state_t st;
  e1pm_det_state_t next_st;
  logic mark;
  logic bipolar_violation;
  logic codeword;

  // a mark is seen on either rail; positive rail wins if both are high
  assign mark = vif.pos_mark | vif.neg_mark;
  // same polarity as the previous mark (R4)
  assign bipolar_violation = vif.bit_valid & mark & st.have_mark &
               (vif.neg_mark & ~vif.pos_mark) == st.last_mark_neg;
  // 000V and B00V both leave two zeros right before the violation (R5)
  assign codeword = st.zero_run == 2'h2;

  // symbol history and event decision
  always_comb
  begin
    next_st = st;
    next_st.viol_event = 1'b0;
    if (vif.bit_valid)
    begin
      if (mark)
      begin
        next_st.have_mark = 1'b1;
        next_st.last_mark_neg = vif.neg_mark & ~vif.pos_mark;
        next_st.zero_run = 2'h0;
      end
      else if (st.zero_run != 2'h2)
      begin
        next_st.zero_run = st.zero_run + 2'h1;
      end
      if (bipolar_violation)
      begin
        next_st.have_viol = 1'b1;
        next_st.last_viol_neg = vif.neg_mark & ~vif.pos_mark;
        if (vif.violation_mode_select)
        begin
          // two successive violations of one polarity (R6)
          next_st.viol_event = st.have_viol &
            ((vif.neg_mark & ~vif.pos_mark) == st.last_viol_neg); // R6
        end
        else
        begin
          next_st.viol_event = ~(vif.hdb3_receive_enable & codeword); // R5
        end
      end
    end
  end

  // register the whole state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign vif.viol_event = st.viol_event;

endmodule

// file: verilog/e1pm_error_counters.sv
// e1pm_error_counters: four e1 receive error counters latched per interval
// assumes event inputs are one-cycle pulses synchronous to sys_clk,
// and sys_clk is the receive clock reference at 25 mhz
`timescale 1ns/1ps

// Notes on behaviour
// (R1) all counters latch together each interval
// (R2) holding registers show only previous interval
// (R3) violation count 16 bits, high/low bytes
// (R4) mode 0 counts same-polarity consecutive marks
// (R5) hdb3 substitution violations are not counted
// (R6) mode 1 counts same-polarity successive violations
// (R7) host picks mode to suit line coding
// (R8) violation counting ignores sync loss
// (R9) violation counter saturates, never wraps
// (R10) 10-bit crc4 error counter, no saturation
// (R11) crc and e-bit freeze on fas/crc4 loss
// (R12) e-bit counter counts received zero e bits
// (R13) 12-bit fas word error counter
// (R14) fas counter frozen during loss of sync
// (R15) address 02 packs fas top, crc top
// (R16) address 04 packs fas bottom, e-bit top
// (R17) timer flag marks each interval boundary
// (R18) latch and restart in one cycle
// (R19) holding registers read-only, reads harmless
module e1pm_error_counters
  import e1pm_pkg::*;
#(
  parameter int LONG_CYCLES = INTERVAL_LONG_CYCLES,
  parameter int SHORT_CYCLES = INTERVAL_SHORT_CYCLES
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // receive line symbols
  input wire logic rx_bit_valid,
  input wire logic rx_pos_mark,
  input wire logic rx_neg_mark,
  // framer events and sync state
  input wire logic crc_error_pulse,
  input wire logic ebit_valid,
  input wire logic ebit_value,
  input wire logic fas_error_pulse,
  input wire logic receive_loss_of_sync,
  input wire logic crc_mf_loss_of_sync,
  // interrupt and interval marker
  output logic irq,
  output logic interval_tick
);

  // divider width covers the long interval; the short one fits inside it
  localparam int TW = $clog2(LONG_CYCLES + 1);
  localparam logic [TW-1:0] LONG_LAST = TW'(LONG_CYCLES - 1);
  localparam logic [TW-1:0] SHORT_LAST = TW'(SHORT_CYCLES - 1);

  // every register of the block outside u_detect lives in this one struct; the next-state
  // process fills a copy and a single flop process captures it
  typedef struct packed {
    logic [TW-1:0] timer_cnt;
    logic interval_tick;
    logic [VIOL_W-1:0] run_viol;
    logic [VIOL_W-1:0] hold_viol;
    logic [CRC_W-1:0] run_crc;
    logic [CRC_W-1:0] hold_crc;
    logic [EBIT_W-1:0] run_ebit;
    logic [EBIT_W-1:0] hold_ebit;
    logic [FAS_W-1:0] run_fas;
    logic [FAS_W-1:0] hold_fas;
    logic interval_select;
    logic violation_mode_select;
    logic hdb3_receive_enable;
    logic interval_timer_flag;
    logic interval_timer_mask;
    logic [7:0] rdata;
    logic irq;
  } e1pm_state_t;

  e1pm_state_t st;
  e1pm_state_t next_st;

  logic tick;
  logic viol_inc;
  logic crc_inc;
  logic ebit_inc;
  logic fas_inc;
  logic frame_sync_ok;
  logic [7:0] read_value;

  e1pm_viol_if vif ();

  // line symbols and mode bits to the detector
  assign vif.bit_valid = rx_bit_valid;
  assign vif.pos_mark = rx_pos_mark;
  assign vif.neg_mark = rx_neg_mark;
  assign vif.violation_mode_select = st.violation_mode_select;
  assign vif.hdb3_receive_enable = st.hdb3_receive_enable;

  e1pm_viol_detect u_detect
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .vif(vif)
  );

  // interval boundary from the free-running divider (R1)
  // compare with >= so that a switch to the short interval while the
  // divider is already past its end gives a boundary on the next cycle
  // instead of waiting for the divider to wrap through its full width
  assign tick = st.interval_select ? (st.timer_cnt >= SHORT_LAST) :
                                     (st.timer_cnt >= LONG_LAST); // R17

  // event qualification
  // sync levels gate a pulse in its own cycle; a pulse that meets the
  // cycle where sync returns is counted, one that meets a loss is not
  // violations are never gated by sync state (R8)
  assign viol_inc = vif.viol_event; // R8
  // cas multiframe loss is deliberately not an input here (R11)
  assign frame_sync_ok = ~receive_loss_of_sync & ~crc_mf_loss_of_sync; // R11
  assign crc_inc = crc_error_pulse & frame_sync_ok; // R10
  assign ebit_inc = ebit_valid & ~ebit_value & frame_sync_ok; // R12
  assign fas_inc = fas_error_pulse & ~receive_loss_of_sync; // R14

  // one write strobe aimed at one address; every writable field uses it
  function automatic logic wr_hit
  (
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    begin
      wr_hit = wr && addr == target;
    end
  endfunction

  // the two shared bytes put six frame error bits above the two high
  // bits of a ten-bit counter; the layout is the same at both addresses
  function automatic logic [7:0] pack_shared
  (
    input logic [5:0] fas_part,
    input logic [1:0] top_part
  );
    begin
      pack_shared = {fas_part, top_part};
    end
  endfunction

  // next violation count: hold at all ones so a noisy line never wraps;
  // a wrapped count would report a bad line as a near-clean one
  function automatic logic [VIOL_W-1:0] viol_next
  (
    input logic [VIOL_W-1:0] cur,
    input logic inc
  );
    begin
      if (inc && cur != {VIOL_W{1'b1}})
      begin
        viol_next = cur + VIOL_W'(1);
      end
      else
      begin
        viol_next = cur;
      end
    end
  endfunction

  // read decode; holding registers only change at a boundary
  // one mux serves every address and feeds the read data flop
  always_comb
  begin
    read_value = 8'h00;
    unique case (reg_addr)
      ADDR_VIOL_HIGH:
      begin
        read_value = st.hold_viol[15:8]; // R3
      end
      ADDR_VIOL_LOW:
      begin
        read_value = st.hold_viol[7:0]; // R3
      end
      ADDR_FAS_HIGH_CRC_TOP:
      begin
        read_value = pack_shared(st.hold_fas[11:6], st.hold_crc[9:8]); // R15
      end
      ADDR_CRC_LOW:
      begin
        read_value = st.hold_crc[7:0]; // R15
      end
      ADDR_FAS_LOW_EBIT_TOP:
      begin
        read_value = pack_shared(st.hold_fas[5:0], st.hold_ebit[9:8]); // R16
      end
      ADDR_EBIT_LOW:
      begin
        read_value = st.hold_ebit[7:0]; // R16
      end
      ADDR_CONTROL:
      begin
        read_value[CTRL_INTERVAL_BIT] = st.interval_select;
        read_value[CTRL_VIOL_MODE_BIT] = st.violation_mode_select;
        read_value[CTRL_HDB3_BIT] = st.hdb3_receive_enable;
      end
      ADDR_INT_STATUS:
      begin
        read_value[INT_TIMER_BIT] = st.interval_timer_flag;
      end
      ADDR_INT_MASK:
      begin
        read_value[INT_TIMER_BIT] = st.interval_timer_mask;
      end
      default:
      begin
        // unmapped addresses read as zero
        read_value = 8'h00;
      end
    endcase
  end

  // next-state logic for timer, counters and registers
  always_comb
  begin
    next_st = st;
    next_st.interval_tick = tick;

    // divider restarts at each boundary
    // it never stops, so boundary spacing holds across host accesses
    if (tick)
    begin
      next_st.timer_cnt = '0;
    end
    else
    begin
      next_st.timer_cnt = st.timer_cnt + TW'(1);
    end

    // running counters; a boundary copies and restarts in one cycle,
    // seeding with this cycle's event so none is lost (R18)
    if (tick)
    begin
      next_st.hold_viol = st.run_viol; // R1
      next_st.hold_crc = st.run_crc; // R1
      next_st.hold_ebit = st.run_ebit; // R1
      next_st.hold_fas = st.run_fas; // R2
      next_st.run_viol = {{(VIOL_W-1){1'b0}}, viol_inc}; // R18
      next_st.run_crc = {{(CRC_W-1){1'b0}}, crc_inc}; // R18
      next_st.run_ebit = {{(EBIT_W-1){1'b0}}, ebit_inc}; // R18
      next_st.run_fas = {{(FAS_W-1){1'b0}}, fas_inc}; // R18
    end
    else
    begin
      // hold at all ones instead of wrapping (R9)
      next_st.run_viol = viol_next(st.run_viol, viol_inc); // R9
      // these cannot exceed range within one second, so they just add
      if (crc_inc)
      begin
        next_st.run_crc = st.run_crc + CRC_W'(1); // R10
      end
      if (ebit_inc)
      begin
        next_st.run_ebit = st.run_ebit + EBIT_W'(1); // R12
      end
      if (fas_inc)
      begin
        next_st.run_fas = st.run_fas + FAS_W'(1); // R13
      end
    end

    // control register; counter addresses ignore writes (R19)
    if (wr_hit(reg_wr, reg_addr, ADDR_CONTROL))
    begin
      next_st.interval_select = reg_wdata[CTRL_INTERVAL_BIT];
      next_st.violation_mode_select = reg_wdata[CTRL_VIOL_MODE_BIT];
      next_st.hdb3_receive_enable = reg_wdata[CTRL_HDB3_BIT];
    end
    if (wr_hit(reg_wr, reg_addr, ADDR_INT_MASK))
    begin
      next_st.interval_timer_mask = reg_wdata[INT_TIMER_BIT];
    end

    // sticky flag: write one clears, a boundary in the same cycle wins
    if (wr_hit(reg_wr, reg_addr, ADDR_INT_STATUS) && reg_wdata[INT_TIMER_BIT])
    begin
      next_st.interval_timer_flag = 1'b0;
    end
    if (tick)
    begin
      next_st.interval_timer_flag = 1'b1; // R17
    end

    // level interrupt follows the registered flag and mask
    // taken from the next state so irq moves in the same cycle as the
    // flag and mask flops, while still coming straight from a flop
    next_st.irq = next_st.interval_timer_flag & next_st.interval_timer_mask;

    // read data stand only in the cycle after the strobe (R19)
    // returning zero outside an answer keeps a stale byte off the bus
    if (reg_rd)
    begin
      next_st.rdata = read_value;
    end
    else
    begin
      next_st.rdata = 8'h00;
    end
  end

  // register the whole state
  // control and interrupt fields take their package reset values; the
  // counters start from zero, so the first interval is a full one
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.interval_select <= CTRL_RESET[CTRL_INTERVAL_BIT];
      st.violation_mode_select <= CTRL_RESET[CTRL_VIOL_MODE_BIT];
      st.hdb3_receive_enable <= CTRL_RESET[CTRL_HDB3_BIT];
      st.interval_timer_flag <= INT_STATUS_RESET[INT_TIMER_BIT];
      st.interval_timer_mask <= INT_MASK_RESET[INT_TIMER_BIT];
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  // no logic between flop and pin keeps the outputs free of glitches
  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign interval_tick = st.interval_tick;

endmodule

// file: tb/e1pm_counters_monitor.sv
// e1pm_counters_monitor: port-level checks of the counter block
// assumes a bind to e1pm_error_counters, one sys_clk domain
`timescale 1ns/1ps
module e1pm_counters_monitor
  import e1pm_pkg::*;
#(
  parameter int LONG_CYCLES = 200
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // interrupt and interval marker
  input wire logic irq,
  input wire logic interval_tick
);
  int gap;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // cycles since the last marker; bounds the longest interval
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap <= 0;
    else
      gap <= interval_tick ? 0 : gap + 1;
  end

  sequence s_quiet;
    (!interval_tick)[*8];
  endsequence
  sequence s_rd_ctrl;
    reg_rd && reg_addr == ADDR_CONTROL;
  endsequence

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h12 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_bits: assert property (s_rd_ctrl |=> reg_rdata[7:3] == 5'h00)
    else $error("control spare bits set");
  a_stat_bits: assert property (reg_rd && reg_addr == ADDR_INT_STATUS
    |=> reg_rdata[7:1] == 7'h00) else $error("status spare bits set");
  a_irq_rise: assert property ($rose(irq) |-> interval_tick ||
    $past(reg_wr)) else $error("irq rose without a cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq fell without a host write");
  a_tick_pulse: assert property (interval_tick |=> s_quiet)
    else $error("interval markers too close");
  a_tick_gap: assert property (gap <= LONG_CYCLES)
    else $error("interval longer than the long limit");
endmodule

// file: tb/e1pm_line_model.sv
// e1pm_line_model: line decoder stand-in, one symbol per request
// assumes requests change just after a rising edge of sys_clk
`timescale 1ns/1ps
module e1pm_line_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request: sym 1 positive mark, 2 negative mark, else zero
  input wire logic go,
  input wire logic [1:0] sym,
  // decoder outputs
  output logic bit_valid,
  output logic pos_mark,
  output logic neg_mark
);
  // between bit times the marks toggle, so stale levels never pass
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_valid <= 1'b0;
      pos_mark <= 1'b0;
      neg_mark <= 1'b0;
    end
    else
    begin
      bit_valid <= go;
      pos_mark <= go ? sym == 2'h1 : !pos_mark;
      neg_mark <= go ? sym == 2'h2 : !neg_mark;
    end
  end
endmodule

// file: tb/tb_e1_error_performance_counters.sv
// tb_e1_error_performance_counters: directed checks of the counters
// assumes shortened intervals by parameter and a line model on rx pins
`timescale 1ns/1ps
module tb_e1_error_performance_counters
  import e1pm_pkg::*;
;
  localparam int LONG_CYCLES = 66000;
  localparam int SHORT = 50;
  logic sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic go = 1'b0, crc = 1'b0, ebv = 1'b0, ebd = 1'b0, fas = 1'b0;
  logic los = 1'b0, mf_los = 1'b0, irq, tick, bv, pm, nm;
  logic [1:0] sym = 2'h0;
  int mismatches = 0, num_checks = 0, wcnt;

  // 25 mhz clock
  always #20 sys_clk = ~sys_clk;

  e1pm_error_counters #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT))
    DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd_s), .reg_rdata(rdata),
    .rx_bit_valid(bv), .rx_pos_mark(pm), .rx_neg_mark(nm),
    .crc_error_pulse(crc), .ebit_valid(ebv), .ebit_value(ebd),
    .fas_error_pulse(fas), .receive_loss_of_sync(los),
    .crc_mf_loss_of_sync(mf_los), .irq(irq), .interval_tick(tick));
  e1pm_line_model u_line (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .sym(sym), .bit_valid(bv), .pos_mark(pm), .neg_mark(nm));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrt(input logic [7:0] a, d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge sys_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // waits for the next marker, bounded at 70000 cycles, above the 66000-cycle long interval
  task automatic wt;
    wcnt = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      wcnt++;
    end
    while (tick !== 1'b1 && wcnt < 70000);
    if (tick !== 1'b1)
    begin
      mismatches++;
      stop_test;
    end
  endtask
  // symbols two bits each, oldest first: 1 positive, 2 negative
  task automatic sq(input logic [15:0] p, input int n);
    for (int k = n - 1; k >= 0; k--)
    begin
      @(posedge sys_clk);
      go <= 1'b1;
      sym <= p[2*k +: 2];
    end
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  // one framer cycle: crc, e-bit valid, e-bit value, fas
  task automatic pl(input logic [3:0] m);
    @(posedge sys_clk);
    {crc, ebv, ebd, fas} <= m;
    @(posedge sys_clk);
    {crc, ebv, fas} <= 3'h0;
  endtask
  task automatic rd4(input logic [31:0] e);
    for (int a = 2; a < 6; a++)
      rd(a[7:0], e[8*(5-a) +: 8]);
  endtask

  task automatic t_regs;
    for (int a = 0; a < 6; a++)
    begin
      rd(a[7:0], 8'h00);
      wrt(a[7:0], 8'hff);
      rd(a[7:0], 8'h00);
    end
    rd(ADDR_INT_MASK, 8'h00);
    rd(8'h20, 8'h00);
    wrt(ADDR_CONTROL, 8'h07);
    rd(ADDR_CONTROL, 8'h07);
    wrt(ADDR_CONTROL, 8'h01);
    sq(16'h0001, 1);
    $display("t_regs done");
  endtask
  task automatic t_irq;
    wt;
    rd(ADDR_INT_STATUS, 8'h01);
    chk("irq", 16'h0, {15'h0, irq});
    wrt(ADDR_INT_MASK, 8'h01);
    @(posedge sys_clk);
    #1;
    chk("irq", 16'h1, {15'h0, irq});
    wrt(ADDR_INT_STATUS, 8'h01);
    @(posedge sys_clk);
    #1;
    chk("irq", 16'h0, {15'h0, irq});
    wt;
    wt;
    chk("period", SHORT[15:0], wcnt[15:0]);
    wrt(ADDR_INT_MASK, 8'h00);
    $display("t_irq done");
  endtask
  // bipolar mode with sync lost: violations count, framer events do not
  task automatic t_bpv;
    wt;
    los <= 1'b1;
    mf_los <= 1'b1;
    sq(16'h09a5, 6);
    pl(4'hd);
    wt;
    los <= 1'b0;
    mf_los <= 1'b0;
    rd(ADDR_VIOL_HIGH, 8'h00);
    rd(ADDR_VIOL_LOW, 8'h02);
    rd4(32'h0);
    $display("t_bpv done");
  endtask
  task automatic t_hdb3;
    wt;
    wrt(ADDR_CONTROL, 8'h05);
    sq(16'h0825, 6);
    mf_los <= 1'b1;
    pl(4'hd);
    mf_los <= 1'b0;
    pl(4'hd);
    pl(4'he);
    wt;
    rd(ADDR_VIOL_LOW, 8'h01);
    rd4(32'h00020801);
    $display("t_hdb3 done");
  endtask
  task automatic t_cv;
    wt;
    wrt(ADDR_CONTROL, 8'h07);
    sq(16'ha69a, 8);
    wt;
    rd(ADDR_VIOL_LOW, 8'h02);
    $display("t_cv done");
  endtask
  // long interval: violation count saturates, wide counts in packing
  task automatic t_sat;
    wt;
    wrt(ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 65600; i++)
    begin
      @(posedge sys_clk);
      go <= 1'b1;
      sym <= 2'h1;
      crc <= i < 773;
      ebv <= i < 518;
      ebd <= 1'b0;
      fas <= i < 2748;
    end
    @(posedge sys_clk);
    go <= 1'b0;
    wt;
    rd(ADDR_VIOL_HIGH, 8'hff);
    rd(ADDR_VIOL_LOW, 8'hff);
    rd4(32'hab05f206);
    wrt(ADDR_CONTROL, 8'h01);
    wt;
    rd(ADDR_VIOL_LOW, 8'h00);
    $display("t_sat done");
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    t_irq;
    t_bpv;
    t_hdb3;
    t_cv;
    t_sat;
    stop_test;
  end
endmodule

bind e1pm_error_counters e1pm_counters_monitor #(.LONG_CYCLES(LONG_CYCLES))
  u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .interval_tick(interval_tick));
